// ==== rtl/srce_bcd_counter.sv ====
// Purpose: decimal counter, one bcd digit per nibble, wraps at all nines
// Assumes: clear has priority over increment
// Notes: used for cycle and event counts
`timescale 1ns/1ps
module srce_bcd_counter
    import srce_pkg::*;
#(
    parameter int DIGITS = 4
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic inc,
    output logic [4*DIGITS-1:0] count_r
);
    logic [DIGITS:0] carry;
    logic [4*DIGITS-1:0] count_nxt;

    assign carry[0] = inc;
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++)
        begin : g_digit
            wire logic [3:0] d = count_r[4*g +: 4];
            assign carry[g+1] = carry[g] && (d == SRCE_DIGIT_MAX);
            assign count_nxt[4*g +: 4] = !carry[g] ? d :
                ((d == SRCE_DIGIT_MAX) ? 4'h0 : d + 4'h1);
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_r <= '0;
        else if (clr)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end
endmodule // srce_bcd_counter

// ==== rtl/srce_engine.sv ====
// Purpose: compares a fresh source record against the reference memory
// Assumes: trigger logic pulses trig_done after sequence and delay
// Notes: memory reads are combinational arrays, one word per cycle
// What this block does
// - after trigger and delay, record source, compare against reference, then re-arm unless halted
// - halt mode stops further recording once equal or unequal condition holds
// - in halt mode the serial port sends the words that failed to compare
// - each halt-mode dump carries the cycle and event counter values
// - count mode advances a five digit cycle counter on every recording
// - count mode advances a 0..9999 event counter only when condition agrees
// - search moves the cursor to the next matching or non-matching location
// - compare window has a source address range and an independent reference start address
// - on a hit, present that address and the nineteen following
// - skew tolerance accepts reference data within zero to nine positions
// - listed data inverts each input group where negative polarity is chosen
// - source and reference memories are 48 bits by 1024 words
// - copy command moves the whole source memory into the reference
`timescale 1ns/1ps
module srce_engine
    import srce_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    input wire logic cond_neq,
    input wire logic run_start,
    input wire logic trig_done,
    input wire logic smp_valid,
    input wire logic [SRCE_DW-1:0] smp_data,
    input wire logic search_cmd,
    input wire logic copy_cmd,
    input wire logic [SRCE_AW-1:0] src_lo,
    input wire logic [SRCE_AW-1:0] src_hi,
    input wire logic [SRCE_AW-1:0] ref_lo,
    input wire logic skew_en,
    input wire logic [SRCE_SKEW_W-1:0] skew,
    input wire logic [SRCE_GROUPS-1:0] neg_pol,
    input wire logic list_mem_ref,
    input wire logic [SRCE_AW-1:0] list_addr,
    input wire logic ref_wr,
    input wire logic [SRCE_AW-1:0] ref_wr_addr,
    input wire logic [SRCE_DW-1:0] ref_wr_data,
    input wire logic ser_ready,
    output logic busy,
    output logic recording,
    output logic halted_r,
    output logic [SRCE_AW-1:0] cursor_r,
    output logic found_r,
    output logic show_valid_r,
    output logic [SRCE_AW-1:0] show_addr_r,
    output logic [SRCE_DW-1:0] show_data_r,
    output logic ser_en,
    output logic ser_valid,
    output logic [SRCE_DW-1:0] ser_data_r,
    output logic [SRCE_AW-1:0] ser_addr_r,
    output logic [4*SRCE_CYC_DIGITS-1:0] cyc_count,
    output logic [4*SRCE_EVT_DIGITS-1:0] evt_count,
    output logic [SRCE_DW-1:0] list_data_r
);
    logic [SRCE_DW-1:0] src_mem [SRCE_DEPTH];
    logic [SRCE_DW-1:0] ref_mem [SRCE_DEPTH];
    srce_state_t state_r;
    logic [SRCE_AW-1:0] addr_r;
    logic [SRCE_AW-1:0] roff_r;
    logic [4:0] show_cnt_r;
    logic [2:0] dump_cnt_r;
    logic any_hit_r;
    logic dumping_r;
    logic hit;
    logic word_eq;
    logic cyc_inc;
    logic evt_inc;
    logic last_addr;

    function automatic logic [SRCE_AW-1:0] ref_index(input logic [SRCE_AW-1:0] sa,
        input logic [SRCE_AW-1:0] off, input logic signed [4:0] sh);
        ref_index = SRCE_AW'(sa + off + SRCE_AW'(sh));
    endfunction

    // compare word with optional skew window around the reference position
    always_comb
    begin
        logic signed [4:0] k;
        k = '0;
        word_eq = src_mem[addr_r] == ref_mem[ref_index(addr_r, roff_r, 5'sd0)];
        if (skew_en)
        begin
            for (int i = 1; i <= int'(SRCE_SKEW_MAX); i++)
            begin
                k = 5'(i);
                if (i <= int'(skew) && (src_mem[addr_r] ==
                    ref_mem[ref_index(addr_r, roff_r, k)] ||
                    src_mem[addr_r] == ref_mem[ref_index(addr_r, roff_r, -k)]))
                    word_eq = 1'b1;
            end
        end
    end
    assign hit = cond_neq ? !word_eq : word_eq;
    assign last_addr = addr_r == src_hi;

    assign busy = state_r != SRCE_IDLE && state_r != SRCE_HALTED;
    assign recording = state_r == SRCE_REC;
    assign ser_en = mode == SRCE_MODE_HALT;
    assign ser_valid = dumping_r;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= SRCE_IDLE;
            addr_r <= '0;
            roff_r <= '0;
            show_cnt_r <= '0;
            any_hit_r <= 1'b0;
            halted_r <= 1'b0;
            cursor_r <= '0;
            found_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                SRCE_IDLE:
                begin
                    if (run_start)
                        halted_r <= 1'b0;
                    if (copy_cmd)
                    begin
                        addr_r <= '0;
                        state_r <= SRCE_COPY;
                    end
                    else if (search_cmd)
                    begin
                        addr_r <= SRCE_AW'(cursor_r + 1'b1);
                        roff_r <= SRCE_AW'(ref_lo - src_lo);
                        found_r <= 1'b0;
                        state_r <= SRCE_SEARCH;
                    end
                    else if (trig_done && mode != SRCE_MODE_OFF && !halted_r)
                    begin
                        addr_r <= '0;
                        state_r <= SRCE_REC;
                    end
                end
                SRCE_REC:
                    if (smp_valid)
                    begin
                        addr_r <= SRCE_AW'(addr_r + 1'b1);
                        if (addr_r == SRCE_AW'(SRCE_DEPTH - 1))
                        begin
                            addr_r <= src_lo;
                            roff_r <= SRCE_AW'(ref_lo - src_lo);
                            any_hit_r <= 1'b0;
                            state_r <= SRCE_CMP;
                        end
                    end
                SRCE_CMP:
                    if (!dumping_r)
                    begin
                        if (hit)
                            any_hit_r <= 1'b1;
                        if (last_addr)
                        begin
                            if (mode == SRCE_MODE_HALT && (hit || any_hit_r))
                            begin
                                halted_r <= 1'b1;
                                state_r <= SRCE_HALTED;
                            end
                            else
                                state_r <= SRCE_IDLE;
                        end
                        else
                            addr_r <= SRCE_AW'(addr_r + 1'b1);
                    end
                SRCE_SEARCH:
                    if (hit)
                    begin
                        cursor_r <= addr_r;
                        found_r <= 1'b1;
                        show_cnt_r <= '0;
                        state_r <= SRCE_SHOW;
                    end
                    else if (last_addr)
                        state_r <= SRCE_IDLE;
                    else
                        addr_r <= SRCE_AW'(addr_r + 1'b1);
                SRCE_SHOW:
                begin
                    addr_r <= SRCE_AW'(addr_r + 1'b1);
                    show_cnt_r <= show_cnt_r + 5'h1;
                    if (show_cnt_r == SRCE_SHOW_LAST)
                        state_r <= SRCE_IDLE;
                end
                SRCE_COPY:
                begin
                    addr_r <= SRCE_AW'(addr_r + 1'b1);
                    if (addr_r == SRCE_AW'(SRCE_DEPTH - 1))
                        state_r <= SRCE_IDLE;
                end
                SRCE_HALTED:
                    if (run_start)
                    begin
                        halted_r <= 1'b0;
                        state_r <= SRCE_IDLE;
                    end
                default:
                    state_r <= SRCE_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (state_r == SRCE_REC && smp_valid)
            src_mem[addr_r] <= smp_data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (state_r == SRCE_COPY)
            ref_mem[addr_r] <= src_mem[addr_r];
        else if (ref_wr)
            ref_mem[ref_wr_addr] <= ref_wr_data;
    end

    // show window of twenty source words from the hit onward
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            show_valid_r <= 1'b0;
            show_addr_r <= '0;
            show_data_r <= '0;
        end
        else
        begin
            show_valid_r <= state_r == SRCE_SHOW;
            show_addr_r <= addr_r;
            show_data_r <= src_mem[addr_r];
        end
    end

    // dump: mismatching word, then counters; stalls compare until ser_ready has taken both words
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dumping_r <= 1'b0;
            dump_cnt_r <= '0;
            ser_data_r <= '0;
            ser_addr_r <= '0;
        end
        else if (!dumping_r)
        begin
            if (state_r == SRCE_CMP && ser_en && !word_eq)
            begin
                dumping_r <= 1'b1;
                ser_data_r <= src_mem[addr_r];
                ser_addr_r <= addr_r;
                dump_cnt_r <= '0;
            end
        end
        else if (ser_ready)
        begin
            dump_cnt_r <= dump_cnt_r + 3'h1;
            if (dump_cnt_r == 3'h0)
                ser_data_r <= SRCE_DW'({cyc_count, evt_count});
            else
                dumping_r <= 1'b0;
        end
    end

    assign cyc_inc = state_r == SRCE_CMP && last_addr && !dumping_r;
    assign evt_inc = cyc_inc && (hit || any_hit_r);

    srce_bcd_counter #(.DIGITS(SRCE_CYC_DIGITS)) u_cyc
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clr(run_start),
        .inc(cyc_inc),
        .count_r(cyc_count)
    );

    srce_bcd_counter #(.DIGITS(SRCE_EVT_DIGITS)) u_evt
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clr(run_start),
        .inc(evt_inc),
        .count_r(evt_count)
    );

    // list view with per-group polarity
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            list_data_r <= '0;
        else
            for (int g = 0; g < SRCE_GROUPS; g++)
                list_data_r[g*SRCE_GW +: SRCE_GW] <= (list_mem_ref ?
                    ref_mem[list_addr][g*SRCE_GW +: SRCE_GW] :
                    src_mem[list_addr][g*SRCE_GW +: SRCE_GW]) ^
                    {SRCE_GW{neg_pol[g]}};
    end

    property p_halt_stops;
        @(posedge sys_clk) disable iff (!rst_n)
        halted_r |-> !recording;
    endproperty
    a_halt_stops: assert property (p_halt_stops) else $error("recording while halted");

    // twenty show cycles split so no repetition count exceeds eight
    sequence s_show8;
        (state_r == SRCE_SHOW) [*8];
    endsequence

    sequence s_show4;
        (state_r == SRCE_SHOW) [*4];
    endsequence

    property p_show_len;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(state_r == SRCE_SHOW) |-> s_show8 ##1 s_show8 ##1 s_show4 ##1 (state_r != SRCE_SHOW);
    endproperty
    a_show_len: assert property (p_show_len) else $error("show window not twenty words");

    property p_evt_needs_cyc;
        @(posedge sys_clk) disable iff (!rst_n)
        evt_inc |-> cyc_inc;
    endproperty
    a_evt_needs_cyc: assert property (p_evt_needs_cyc) else $error("event without cycle");

    property p_run_clears;
        @(posedge sys_clk) disable iff (!rst_n)
        run_start |=> cyc_count == '0 && evt_count == '0;
    endproperty
    a_run_clears: assert property (p_run_clears) else $error("counters not cleared");

    property p_dump_counters;
        @(posedge sys_clk) disable iff (!rst_n)
        dumping_r && ser_ready && dump_cnt_r == 3'h0 |=>
            ser_data_r == SRCE_DW'({$past(cyc_count), $past(evt_count)});
    endproperty
    a_dump_counters: assert property (p_dump_counters) else $error("dump lacks counters");

    property p_dump_only_halt;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(dumping_r) |-> $past(mode) == SRCE_MODE_HALT;
    endproperty
    a_dump_only_halt: assert property (p_dump_only_halt) else $error("dump outside halt");

    property p_rec_to_cmp;
        @(posedge sys_clk) disable iff (!rst_n)
        recording && smp_valid && addr_r == SRCE_AW'(SRCE_DEPTH - 1) |=> state_r == SRCE_CMP;
    endproperty
    a_rec_to_cmp: assert property (p_rec_to_cmp) else $error("no compare after record");

    property p_search_hit;
        @(posedge sys_clk) disable iff (!rst_n)
        state_r == SRCE_SEARCH && hit |=> found_r && cursor_r == $past(addr_r);
    endproperty
    a_search_hit: assert property (p_search_hit) else $error("cursor not moved");
endmodule // srce_engine

// ==== rtl/srce_pkg.sv ====
// Purpose: shared constants and types of the source/reference compare engine
// Assumes: one 100 MHz clock, memories 48 x 1024
// Notes: bcd counters hold one decimal digit per nibble
package srce_pkg;
    localparam int SRCE_DW = 48;
    localparam int SRCE_AW = 10;
    localparam int SRCE_DEPTH = 1024;
    localparam int SRCE_GROUPS = 6;
    localparam int SRCE_GW = 8;
    localparam int SRCE_CYC_DIGITS = 5;
    localparam int SRCE_EVT_DIGITS = 4;
    localparam int SRCE_SKEW_W = 4;
    localparam logic [3:0] SRCE_SKEW_MAX = 4'h9;
    localparam logic [4:0] SRCE_SHOW_LAST = 5'h13;
    localparam logic [3:0] SRCE_DIGIT_MAX = 4'h9;
    localparam logic [2:0] SRCE_DUMP_WORDS = 3'h6;
    localparam logic [1:0] SRCE_MODE_OFF = 2'h0;
    localparam logic [1:0] SRCE_MODE_HALT = 2'h1;
    localparam logic [1:0] SRCE_MODE_COUNT = 2'h2;

    typedef enum logic [2:0] {
        SRCE_IDLE = 3'b000,
        SRCE_REC = 3'b001,
        SRCE_CMP = 3'b010,
        SRCE_SEARCH = 3'b011,
        SRCE_COPY = 3'b100,
        SRCE_SHOW = 3'b101,
        SRCE_HALTED = 3'b110
    } srce_state_t;
endpackage

// ==== tb/srce_engine_tb_top.sv ====
// Purpose: self-checking bench of the compare engine
// Assumes: partner feeds samples and sinks the serial dump
// Notes: skew and window offset ride on the search scenario
`timescale 1ns/1ps
module srce_engine_tb_top
    import srce_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [3:0] cmd = 4'h0;
    logic cond_neq = 1'b0, skew_en = 1'b0, list_mem_ref = 1'b0, ref_wr = 1'b0, slow = 1'b0;
    logic [SRCE_AW-1:0] src_lo = 10'h000, src_hi = 10'h3ff, ref_lo = 10'h000, list_addr = 10'h000;
    logic [SRCE_AW-1:0] ref_wr_addr = 10'h000;
    logic [SRCE_SKEW_W-1:0] skew = 4'h0;
    logic [SRCE_GROUPS-1:0] neg_pol = 6'h00;
    logic [SRCE_DW-1:0] ref_wr_data = 48'h0;
    logic smp_valid, ser_ready, busy, recording, halted_r, found_r, show_valid_r, ser_en, ser_valid;
    logic [SRCE_DW-1:0] smp_data, show_data_r, ser_data_r, list_data_r;
    logic [SRCE_AW-1:0] cursor_r, show_addr_r, ser_addr_r;
    logic [4*SRCE_CYC_DIGITS-1:0] cyc_count;
    logic [4*SRCE_EVT_DIGITS-1:0] evt_count;
    int err_count = 0, compares = 0, cyc_n = 0;
    srce_engine dut (.sys_clk, .rst_n, .mode, .cond_neq, .run_start(cmd[0]), .trig_done(cmd[1]),
        .smp_valid, .smp_data, .search_cmd(cmd[3]), .copy_cmd(cmd[2]), .src_lo, .src_hi, .ref_lo,
        .skew_en, .skew, .neg_pol, .list_mem_ref, .list_addr, .ref_wr, .ref_wr_addr, .ref_wr_data,
        .ser_ready, .busy, .recording, .halted_r, .cursor_r, .found_r, .show_valid_r, .show_addr_r,
        .show_data_r, .ser_en, .ser_valid, .ser_data_r, .ser_addr_r, .cyc_count, .evt_count,
        .list_data_r);
    srce_partner u_far (.sys_clk, .rst_n, .recording, .slow, .ser_valid, .ser_data_r, .ser_addr_r,
        .smp_valid, .smp_data, .ser_ready);
    function automatic logic [SRCE_DW-1:0] pat(input logic [SRCE_AW-1:0] a);
        return {a, a, a, a, 8'h3c};
    endfunction
    task automatic chk(input logic [SRCE_DW-1:0] seen, input logic [SRCE_DW-1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // k: 0 run start, 1 trigger done, 2 copy, 3 search
    task automatic pulse(input int k);
        @(posedge sys_clk) cmd <= 4'h1 << k;
        @(posedge sys_clk) cmd <= 4'h0;
        #1;
    endtask
    task automatic run_pass();
        int n;
        pulse(1);
        chk(busy, 1'b1);
        n = 0;
        while (busy !== 1'b0 && n < 5000)
        begin
            tick(1);
            n++;
        end
        chk(busy, 1'b0);
    endtask
    task automatic rd(input logic [SRCE_AW-1:0] a, input logic [SRCE_DW-1:0] exp);
        @(posedge sys_clk)
        begin
            list_mem_ref <= 1'b1;
            list_addr <= a;
        end
        tick(1);
        chk(list_data_r, exp);
    endtask
    task automatic t_copy();
        run_pass();
        chk(cyc_count, 20'h00001);
        pulse(2);
        tick(1100);
        rd(10'h000, pat(10'h000));
        rd(10'h3ff, pat(10'h3ff));
        @(posedge sys_clk) neg_pol <= 6'h21;
        rd(10'h3ff, pat(10'h3ff) ^ 48'hff00_0000_00ff);
        @(posedge sys_clk) neg_pol <= 6'h00;
        pulse(0);
        chk({cyc_count, evt_count}, 36'h0);
        run_pass();
        chk({cyc_count, evt_count}, 36'h000010001);
        @(posedge sys_clk) cond_neq <= 1'b1;
        run_pass();
        chk({cyc_count, evt_count}, 36'h000020001);
        $display("test copy and count done");
    endtask
    task automatic t_halt();
        int n;
        @(posedge sys_clk)
        begin
            ref_wr <= 1'b1;
            ref_wr_addr <= 10'h005;
            ref_wr_data <= ~pat(10'h005);
            mode <= SRCE_MODE_HALT;
            slow <= 1'b1;
        end
        @(posedge sys_clk) ref_wr <= 1'b0;
        run_pass();
        chk(halted_r, 1'b1);
        chk(ser_en, 1'b1);
        n = 0;
        while (u_far.rx_n < 2 && n < 300)
        begin
            tick(1);
            n++;
        end
        chk(u_far.rx_r[0], pat(10'h005));
        chk(u_far.rx_a_r, 10'h005);
        chk(u_far.rx_r[1][35:0], 36'h000020001);
        pulse(1);
        tick(3);
        chk(recording, 1'b0);
        pulse(0);
        chk({halted_r, cyc_count, evt_count}, 37'h0);
        $display("test halt and dump done");
    endtask
    task automatic find(input logic [SRCE_AW-1:0] a);
        int n;
        pulse(3);
        n = 0;
        while (show_valid_r !== 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        chk(show_addr_r, a);
        chk(show_data_r, pat(a));
        chk(found_r, 1'b1);
        n = 0;
        while (show_valid_r === 1'b1 && n < 50)
        begin
            tick(1);
            n++;
        end
        chk(48'(n), 48'(SRCE_SHOW_LAST) + 48'h1);
        chk(cursor_r, a);
    endtask
    task automatic t_search();
        // second reset mid-run brings the cursor home to zero
        @(posedge sys_clk)
        begin
            rst_n <= 1'b0;
            mode <= SRCE_MODE_OFF;
            slow <= 1'b0;
            src_lo <= 10'h004;
            src_hi <= 10'h014;
            ref_lo <= 10'h004;
        end
        @(posedge sys_clk) rst_n <= 1'b1;
        find(10'h005);
        @(posedge sys_clk) cond_neq <= 1'b0;
        find(10'h006);
        // swapped pair 8/9 only matches one position apart
        @(posedge sys_clk)
        begin
            ref_wr <= 1'b1;
            ref_wr_addr <= 10'h008;
            ref_wr_data <= pat(10'h009);
            cond_neq <= 1'b1;
            skew_en <= 1'b1;
            skew <= 4'h1;
        end
        @(posedge sys_clk)
        begin
            ref_wr_addr <= 10'h009;
            ref_wr_data <= pat(10'h008);
        end
        @(posedge sys_clk) ref_wr <= 1'b0;
        pulse(3);
        tick(30);
        chk(found_r, 1'b0);
        chk(cursor_r, 10'h006);
        @(posedge sys_clk) skew_en <= 1'b0;
        find(10'h008);
        // reference window one word below the source window
        @(posedge sys_clk)
        begin
            cond_neq <= 1'b0;
            ref_lo <= 10'h003;
        end
        find(10'h009);
        $display("test search done");
    endtask
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc_n++;
        if (cyc_n == 40000)
        begin
            err_count++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk) mode <= SRCE_MODE_COUNT;
        tick(1);
        chk({cyc_count, evt_count}, 36'h0);
        t_copy();
        t_halt();
        t_search();
        give_verdict();
    end
endmodule // srce_engine_tb_top

// ==== tb/srce_partner.sv ====
// Purpose: far side of the engine: sample source and serial sink
// Assumes: a raised sample is taken at the next edge while recording
// Notes: slow halves sample and ready rates; idle data toggles
`timescale 1ns/1ps
module srce_partner
    import srce_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic recording,
    input wire logic slow,
    input wire logic ser_valid,
    input wire logic [SRCE_DW-1:0] ser_data_r,
    input wire logic [SRCE_AW-1:0] ser_addr_r,
    output logic smp_valid,
    output logic [SRCE_DW-1:0] smp_data,
    output logic ser_ready
);
    logic [SRCE_AW-1:0] idx_r;
    logic [SRCE_AW-1:0] idx_nxt;
    logic [SRCE_AW-1:0] rx_a_r;
    logic [SRCE_DW-1:0] rx_r [0:1];
    logic tick_r;
    logic nv;
    int rx_n;
    function automatic logic [SRCE_DW-1:0] pat(input logic [SRCE_AW-1:0] a);
        return {a, a, a, a, 8'h3c};
    endfunction
    assign idx_nxt = recording ? idx_r + {9'h000, smp_valid} : 10'h000;
    assign nv = recording && (!slow || tick_r);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idx_r <= '0;
            tick_r <= 1'b0;
            smp_valid <= 1'b0;
            smp_data <= '0;
            ser_ready <= 1'b0;
            rx_n <= 0;
        end
        else
        begin
            tick_r <= ~tick_r;
            idx_r <= idx_nxt;
            smp_valid <= nv;
            // stale word inverted so a missed strobe cannot look valid
            smp_data <= nv ? pat(idx_nxt) : ~smp_data;
            ser_ready <= !slow || tick_r;
            if (ser_valid && ser_ready)
            begin
                rx_r[rx_n[0]] <= ser_data_r;
                if (rx_n == 0)
                    rx_a_r <= ser_addr_r;
                rx_n <= rx_n + 1;
            end
        end
    end
endmodule // srce_partner
